// ---- hw/hsync_genlock_cfg.svh ----
`ifndef HSYNC_GENLOCK_CFG_SVH
`define HSYNC_GENLOCK_CFG_SVH

// byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_INT_STATUS    8'h08
`define REG_INT_MASK      8'h0C
`define REG_PHASE_ERR     8'h10

// control fields
`define CTRL_LOOP_EN_BIT  0
`define CTRL_RESET        1'b1

// status fields
`define STS_LOCKED_BIT    0
`define STS_MODE_LSB      1
`define STS_PUMP_LSB      3
`define STS_DIVSEL_BIT    5
`define STS_DIVISOR_LSB   16

// interrupt bits
`define INT_LOCK_GAINED   0
`define INT_LOCK_LOST     1
`define INT_REALIGN       2
`define INT_W             3

// divisor table
`define DIV_000           11'h353
`define DIV_001           11'h360
`define DIV_010           11'h3B0
`define DIV_011           11'h46F
`define DIV_100           11'h2AA
`define DIV_101           11'h35A
`define DIV_110           11'h30C
`define DIV_111           11'h38E

// timing
`define SYS_CLK_MHZ       125
`define SYNC_DELAY_NS     200
`define SYNC_DELAY_CYC    ((`SYNC_DELAY_NS * `SYS_CLK_MHZ + 999) / 1000)
`define LOCK_WINDOW_NS    50
`define LOCK_WINDOW_CYC   ((`LOCK_WINDOW_NS * `SYS_CLK_MHZ) / 1000)

`endif

// ---- hw/hsync_genlock_pkg.sv ----
`default_nettype none
package hsync_genlock_pkg;

    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_FAST   = 2'b01,
        MODE_COAST  = 2'b10,
        MODE_NONE   = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        PUMP_HIZ    = 2'b00,
        PUMP_SOURCE = 2'b01,
        PUMP_SINK   = 2'b10
    } pump_e;

    typedef enum logic {
        LK_HUNT   = 1'b0,
        LK_LOCKED = 1'b1
    } lock_e;

    typedef struct packed {
        logic msb;
        logic mid;
        logic lsb;
    } divsel_s;

    typedef struct packed {
        logic up;
        logic down;
    } pfd_s;

endpackage
`default_nettype wire

// ---- hw/sync_filter3.sv ----
`default_nettype none
module sync_filter3 #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] stable_q
);
    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;
    logic [WIDTH-1:0] stage3_q;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1_q <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end else begin
            stage1_q <= rawIn;
            stage2_q <= stage1_q;
            stage3_q <= stage2_q;
        end
    end

    // a bit only moves once two settled samples agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    stable_q[i] <= 1'b0;
                end else if (stage2_q[i] == stage3_q[i]) begin
                    stable_q[i] <= stage3_q[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ---- hw/hsync_genlock_pll_logic.sv ----
// Functional notes
// [R01] select pins pick N: 851,864,944,1135,682,858,780,910.
// [R02] delay line sync falling edge about 200 ns; delayed edge is reference.
// [R03] oscillator feeds divide-by-N counter and a buffered clock output.
// [R04] detector compares divided clock and delayed sync, drives pump commands.
// [R05] sync leads or is faster: pump sources current.
// [R06] sync lags or is slower: pump sinks current.
// [R07] divide select high: internal divider drives divided clock pin, compared.
// [R08] divide select low: pin is input, outside supplies divided clock.
// [R09] mode low normal, mid or floating fast lock, high coast.
// [R10] normal mode corrects until error zero, then pump high impedance.
// [R11] small errors in normal mode keep tracking with lock output low.
// [R12] fast lock resets divided clock on large phase error to align.
// [R13] fast lock reaches near-lock in about two lines; spacing may jump.
// [R14] coast disables detector and holds pump high impedance.
// [R15] controller uses fast lock for irregular sync, then returns to normal.
// [R16] lock output low while locked, pulses high when out of lock.
// [R17] lock only when edge offset is under 50 ns.
// [R18] mode arrives as two-bit code; pump idles high impedance until valid.
// [R19] pump command is one of source, sink, high impedance, never both.
`default_nettype none
`include "hsync_genlock_cfg.svh"
module hsync_genlock_pll_logic
    import hsync_genlock_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              oscillator_input,
    input  wire logic              lineSyncIn,
    input  wire logic              divisor_select_msb,
    input  wire logic              divisor_select_mid,
    input  wire logic              divisor_select_lsb,
    input  wire logic              divideSelect,
    input  wire logic [1:0]        modeCode,
    input  wire logic              divided_clock_pin_in,
    output logic                   divided_clock_pin_out,
    output logic                   divided_clock_pin_oe,
    output logic                   clockOut,
    output logic                   pumpSource,
    output logic                   pumpSink,
    output logic                   lock_indicator_out,
    output logic                   irq
);
    localparam logic [7:0]  DELAY_CYC = 8'(`SYNC_DELAY_CYC);
    localparam logic [15:0] LOCK_CYC  = 16'(`LOCK_WINDOW_CYC);

    function automatic logic [10:0] divisorOf(input divsel_s sel);
        case (sel)
            3'b000:  divisorOf = `DIV_000;
            3'b001:  divisorOf = `DIV_001;
            3'b010:  divisorOf = `DIV_010;
            3'b011:  divisorOf = `DIV_011;
            3'b100:  divisorOf = `DIV_100;
            3'b101:  divisorOf = `DIV_101;
            3'b110:  divisorOf = `DIV_110;
            default: divisorOf = `DIV_111;
        endcase
    endfunction

    // pins cross into sys_clk here
    logic [8:0] pinsSync;
    sync_filter3 #(.WIDTH(9)) u_pins (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .rawIn    ({modeCode, divideSelect, divisor_select_msb, divisor_select_mid,
                    divisor_select_lsb, divided_clock_pin_in, lineSyncIn,
                    oscillator_input}),
        .stable_q (pinsSync)
    );

    logic    oscLevel;
    logic    syncLevel;
    logic    extDivLevel;
    divsel_s divSel;
    logic    intDivider;
    mode_e   mode;
    assign oscLevel    = pinsSync[0];
    assign syncLevel   = pinsSync[1];
    assign extDivLevel = pinsSync[2];
    assign divSel      = divsel_s'(pinsSync[5:3]);
    assign intDivider  = pinsSync[6];
    assign mode        = mode_e'(pinsSync[8:7]);

    logic        oscPrev_q;
    logic        syncPrev_q;
    logic        extPrev_q;
    logic        modeValid_q;
    logic        loopEnable_q;
    logic [7:0]  delayCnt_q;
    logic        refEdge_q;
    logic [10:0] divCnt_q;
    logic [10:0] divisor;
    logic        oscRise;
    logic        intWrap;
    logic        divEdge;
    logic [15:0] sinceDiv_q;
    logic        realign;
    pfd_s        pfd_q;
    pfd_s        pfd_d;
    logic        pfdOn;
    logic [15:0] errCnt_q;
    logic [15:0] lastErr_q;
    lock_e       lock_q;
    logic        lockGained;
    logic        lockLost;
    logic [`INT_W-1:0] intStatus_q;
    logic [`INT_W-1:0] intMask_q;

    assign divisor = divisorOf(divSel); // R01
    assign oscRise = oscLevel & ~oscPrev_q;
    assign intWrap = oscRise && (divCnt_q == divisor - 11'h001);
    // fast lock: reference arrived with no divider edge close by
    assign realign = refEdge_q && (mode == MODE_FAST) && intDivider
                     && (sinceDiv_q > LOCK_CYC); // R12 R13
    assign divEdge = intDivider ? (intWrap | realign)
                                : (extDivLevel & ~extPrev_q); // R07 R08
    assign pfdOn   = loopEnable_q && modeValid_q
                     && (mode == MODE_NORMAL || mode == MODE_FAST); // R14 R18

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            oscPrev_q   <= 1'b0;
            syncPrev_q  <= 1'b0;
            extPrev_q   <= 1'b0;
            modeValid_q <= 1'b0;
        end else begin
            oscPrev_q   <= oscLevel;
            syncPrev_q  <= syncLevel;
            extPrev_q   <= extDivLevel;
            modeValid_q <= (mode != MODE_NONE); // R09 R18
        end
    end

    // buffered oscillator copy
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            clockOut <= 1'b0;
        end else begin
            clockOut <= oscLevel; // R03
        end
    end

    // falling sync edge starts the delay; a new edge restarts it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            delayCnt_q <= 8'h00;
            refEdge_q  <= 1'b0;
        end else begin
            refEdge_q <= (delayCnt_q == 8'h01);
            if (!syncLevel && syncPrev_q) begin
                delayCnt_q <= DELAY_CYC; // R02
            end else if (delayCnt_q != 8'h00) begin
                delayCnt_q <= delayCnt_q - 8'h01;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_q <= 11'h000;
        end else if (realign) begin
            divCnt_q <= 11'h000; // R12
        end else if (oscRise) begin
            if (divCnt_q >= divisor - 11'h001) begin
                divCnt_q <= 11'h000; // R03
            end else begin
                divCnt_q <= divCnt_q + 11'h001;
            end
        end
    end

    // rising divided edge at count zero, half period high
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            divided_clock_pin_out <= 1'b0;
            divided_clock_pin_oe  <= 1'b0;
        end else begin
            divided_clock_pin_out <= intDivider && (divCnt_q < {1'b0, divisor[10:1]}); // R07
            divided_clock_pin_oe  <= intDivider; // R07 R08
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceDiv_q <= 16'hFFFF;
        end else if (divEdge) begin
            sinceDiv_q <= 16'h0000;
        end else if (sinceDiv_q != 16'hFFFF) begin
            sinceDiv_q <= sinceDiv_q + 16'h0001;
        end
    end

    // detector: earlier edge opens its side, the later edge closes both
    always_comb begin
        pfd_d.up   = pfd_q.up | (refEdge_q & ~realign);
        pfd_d.down = pfd_q.down | (divEdge & ~realign);
        if (!pfdOn || (pfd_d.up && pfd_d.down)) begin
            pfd_d = '0; // R04 R10 R14 R19
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pfd_q      <= '0;
            pumpSource <= 1'b0;
            pumpSink   <= 1'b0;
        end else begin
            pfd_q      <= pfd_d;
            pumpSource <= pfd_d.up;   // R05 R19
            pumpSink   <= pfd_d.down; // R06 R19
        end
    end

    // error width in cycles; closing edge decides lock
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            errCnt_q  <= 16'h0000;
            lastErr_q <= 16'h0000;
        end else if (pfd_q.up || pfd_q.down) begin
            if (pfd_d.up || pfd_d.down) begin
                if (errCnt_q != 16'hFFFF) begin
                    errCnt_q <= errCnt_q + 16'h0001;
                end
            end else begin
                lastErr_q <= errCnt_q + 16'h0001;
                errCnt_q  <= 16'h0000;
            end
        end else begin
            errCnt_q <= 16'h0000;
        end
    end

    assign lockGained = (lock_q == LK_HUNT) && !(pfd_d.up || pfd_d.down) && pfdOn
                        && (((pfd_q.up || pfd_q.down) && errCnt_q < LOCK_CYC)
                            || (refEdge_q && divEdge && !realign));
    assign lockLost   = (lock_q == LK_LOCKED) && (errCnt_q >= LOCK_CYC);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_q <= LK_HUNT;
        end else begin
            case (lock_q)
                LK_HUNT:   if (lockGained) lock_q <= LK_LOCKED; // R17
                LK_LOCKED: if (lockLost) lock_q <= LK_HUNT;
                default:   lock_q <= LK_HUNT;
            endcase
        end
    end

    // pulses while an open error outlasts the window
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            lock_indicator_out <= 1'b1;
        end else begin
            lock_indicator_out <= (pfd_q.up || pfd_q.down) && pfdOn
                                  && (errCnt_q >= LOCK_CYC); // R10 R11 R16 R17
        end
    end

    logic              awHeld_q;
    logic              wHeld_q;
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              doWrite;
    logic [`INT_W-1:0] clearBits;
    logic [`INT_W-1:0] events;

    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign events  = {realign, lockLost, lockGained};
    assign clearBits = (doWrite && awAddr_q == `REG_INT_STATUS && wStrb_q[0])
                       ? wData_q[`INT_W-1:0] : '0;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= '0;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q      <= 1'b1;
                awAddr_q      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q      <= 1'b1;
                wData_q      <= s_axi_wdata;
                wStrb_q      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                if (awAddr_q == `REG_CTRL || awAddr_q == `REG_INT_STATUS
                    || awAddr_q == `REG_INT_MASK) begin
                    s_axi_bresp <= 2'h0;
                end else begin
                    s_axi_bresp <= 2'h2;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                awHeld_q      <= 1'b0;
                wHeld_q       <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            loopEnable_q <= `CTRL_RESET;
            intMask_q    <= '0;
        end else if (doWrite && wStrb_q[0]) begin
            if (awAddr_q == `REG_CTRL) begin
                loopEnable_q <= wData_q[`CTRL_LOOP_EN_BIT];
            end else if (awAddr_q == `REG_INT_MASK) begin
                intMask_q <= wData_q[`INT_W-1:0];
            end
        end
    end

    // a fresh event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            intStatus_q <= '0;
            irq         <= 1'b0;
        end else begin
            intStatus_q <= (intStatus_q & ~clearBits) | events;
            irq         <= |(intStatus_q & intMask_q);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= 2'h0;
            s_axi_rdata   <= 32'h0000_0000;
            if (s_axi_araddr == `REG_CTRL) begin
                s_axi_rdata[`CTRL_LOOP_EN_BIT] <= loopEnable_q;
            end else if (s_axi_araddr == `REG_STATUS) begin
                s_axi_rdata[`STS_LOCKED_BIT] <= (lock_q == LK_LOCKED);
                s_axi_rdata[`STS_MODE_LSB +: 2] <= mode;
                s_axi_rdata[`STS_PUMP_LSB +: 2] <= {pumpSink, pumpSource};
                s_axi_rdata[`STS_DIVSEL_BIT] <= intDivider;
                s_axi_rdata[`STS_DIVISOR_LSB +: 11] <= divisor;
            end else if (s_axi_araddr == `REG_INT_STATUS) begin
                s_axi_rdata[`INT_W-1:0] <= intStatus_q;
            end else if (s_axi_araddr == `REG_INT_MASK) begin
                s_axi_rdata[`INT_W-1:0] <= intMask_q;
            end else if (s_axi_araddr == `REG_PHASE_ERR) begin
                s_axi_rdata[15:0] <= lastErr_q;
            end else begin
                s_axi_rresp <= 2'h2;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- tb/genlock_sva.sv ----
`default_nettype none
module genlock_sva
    import hsync_genlock_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       reset_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic       divideSelect,
    input wire logic [1:0] modeCode,
    input wire logic       divided_clock_pin_out,
    input wire logic       divided_clock_pin_oe,
    input wire logic       pumpSource,
    input wire logic       pumpSink,
    input wire logic       lock_indicator_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire logic pumping = pumpSource || pumpSink;
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // filter and detector latency
    sequence detector_off;
        (modeCode == MODE_COAST || modeCode == MODE_NONE) [*8];
    endsequence
    a_pump_exclusive: assert property (!(pumpSource && pumpSink))
        else $error("pump both ways");
    a_coast_quiet: assert property (detector_off |-> !pumping && !lock_indicator_out)
        else $error("pump active in coast");
    a_oe_follows: assert property ($stable(divideSelect) [*8]
        |-> divided_clock_pin_oe == divideSelect) else $error("pin enable wrong");
    a_ext_quiet: assert property (!divided_clock_pin_oe && !$past(divided_clock_pin_oe)
        |-> !divided_clock_pin_out) else $error("pin driven as input");
    a_lock_window: assert property ($rose(lock_indicator_out) |-> $past(pumping, 3))
        else $error("lock pulse without error");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_write_answer: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
endmodule
bind hsync_genlock_pll_logic genlock_sva genlock_sva_inst (.*);
`default_nettype wire

// ---- tb/genlock_far_side.sv ----
`default_nettype none
module genlock_far_side (
    input  wire logic sys_clk,
    input  wire logic oscEn,
    output var logic  oscOut,
    output var logic  syncOut,
    output var logic  extDivOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        oscOut = 1'b0;
        syncOut = 1'b1;
        extDivOut = 1'b0;
    end
    // odd half period keeps the vco phase unrelated to sys_clk
    always #32.3 oscOut = oscEn ? !oscOut : 1'b0;
    // sync falls at cycle 0; outside divider rises at divAt
    task automatic send_line(input int divAt, input int len);
        for (int c = 0; c < len; c++) begin
            @(posedge sys_clk);
            syncOut <= (c >= 40);
            extDivOut <= (c >= divAt && c < divAt + 20);
        end
    endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import hsync_genlock_pkg::*;
    logic        sys_clk = 0, reset_n = 0, oscEn = 0, divSel = 0;
    logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
    logic        awReady, wReady, bValid, arReady, rValid, divOut, divOe, clockOut;
    logic        pumpSource, pumpSink, lockOut, irq, osc, syncLine, extDiv;
    logic [7:0]  awAddr = 0, arAddr = 0;
    logic [31:0] wData = 0, rData, d;
    logic [1:0]  bResp, rResp, r, modeCode = 2'b00;
    logic [2:0]  sel = 0;
    logic [10:0] divTab [8] = '{11'h353, 11'h360, 11'h3B0, 11'h46F,
                                11'h2AA, 11'h35A, 11'h30C, 11'h38E};
    int          err_total = 0, total_checks = 0, oscRises = 0, clkRises = 0, a, c0;
    realtime     t0;
    always #4 sys_clk = !sys_clk;
    always @(posedge osc) oscRises++;
    always @(posedge clockOut) clkRises++;
    hsync_genlock_pll_logic hsync_genlock_pll_logic_inst (.sys_clk, .reset_n,
        .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
        .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
        .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .oscillator_input(osc), .lineSyncIn(syncLine), .divisor_select_msb(sel[2]),
        .divisor_select_mid(sel[1]), .divisor_select_lsb(sel[0]), .divideSelect(divSel),
        .modeCode, .divided_clock_pin_in(extDiv), .divided_clock_pin_out(divOut),
        .divided_clock_pin_oe(divOe), .clockOut, .pumpSource,
        .pumpSink, .lock_indicator_out(lockOut), .irq);
    genlock_far_side genlock_far_side_inst (.sys_clk, .oscEn, .oscOut(osc),
        .syncOut(syncLine), .extDivOut(extDiv));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat, output logic [1:0] resp);
        logic awDone = 0, wDone = 0;
        @(posedge sys_clk);
        awAddr <= adr;
        wData <= dat;
        awValid <= 1;
        wValid <= 1;
        bReady <= 1;
        while (!(awDone && wDone)) begin
            @(posedge sys_clk);
            if (!awDone && awReady === 1'b1) begin
                awDone = 1;
                awValid <= 0;
            end
            if (!wDone && wReady === 1'b1) begin
                wDone = 1;
                wValid <= 0;
            end
        end
        do @(posedge sys_clk); while (bValid !== 1'b1);
        resp = bResp;
        bReady <= 0;
    endtask
    task automatic rd(input logic [7:0] adr, output logic [31:0] dat, output logic [1:0] resp);
        @(posedge sys_clk);
        arAddr <= adr;
        arValid <= 1;
        rReady <= 1;
        do @(posedge sys_clk); while (arReady !== 1'b1);
        arValid <= 0;
        do @(posedge sys_clk); while (rValid !== 1'b1);
        dat = rData;
        resp = rResp;
        rReady <= 0;
    endtask
    // one line; pins {source, sink, lock} checked mid-line
    task automatic probe(input int divAt, input int at, input logic [2:0] exp);
        fork
            genlock_far_side_inst.send_line(divAt, 300);
            begin
                repeat (at) @(posedge sys_clk);
                #1 chk("pins", {pumpSource, pumpSink, lockOut}, exp);
            end
        join
    endtask
    initial begin
        #480000 err_total++;
        give_verdict();
    end
    initial begin
        void'($urandom(84));
        repeat (16) @(posedge sys_clk);
        chk("outputs in reset", {pumpSource, pumpSink, irq}, 3'h0);
        reset_n <= 1;
        rd(`REG_CTRL, d, r);
        chk("ctrl reset", d, 32'h1);
        rd(`REG_INT_MASK, d, r);
        chk("mask reset", d, 32'h0);
        for (int i = 0; i < 8; i++) begin
            sel <= i[2:0];
            repeat (8) @(posedge sys_clk);
            rd(`REG_STATUS, d, r);
            chk("divisor", d[26:16], divTab[i]);
            chk("div flag", d[5], 1'b0);
        end
        rd(8'h20, d, r);
        chk("unmapped rresp", r, 2'h2);
        wr(8'h24, 32'hFFFF_FFFF, r);
        chk("unmapped bresp", r, 2'h2);
        wr(`REG_INT_MASK, 32'h7, r);
        probe(5, 20, 3'b011);
        probe(80, 60, 3'b101);
        probe(26, 60, 3'b000);
        probe(26, 60, 3'b000);
        rd(`REG_STATUS, d, r);
        chk("locked flag", d[0], 1'b1);
        rd(`REG_INT_STATUS, d, r);
        chk("lock gained event", d[0], 1'b1);
        chk("irq raised", irq, 1'b1);
        wr(`REG_INT_STATUS, 32'h7, r);
        repeat (3) @(posedge sys_clk);
        chk("irq cleared", irq, 1'b0);
        // sync leads by a random margin
        for (int k = 0; k < 4; k++) begin
            a = 40 + $urandom % 60;
            probe(a, a / 2 + 23, 3'b101);
            rd(`REG_PHASE_ERR, d, r);
            chk("phase error", d + 3 >= a - 26 && d <= a - 23, 1'b1);
        end
        rd(`REG_INT_STATUS, d, r);
        chk("lock lost event", d[1], 1'b1);
        wr(`REG_INT_MASK, 32'h0, r);
        repeat (3) @(posedge sys_clk);
        chk("irq masked", irq, 1'b0);
        for (int m = 2; m < 4; m++) begin
            modeCode <= m[1:0];
            repeat (10) @(posedge sys_clk);
            probe(80, 60, 3'b000);
        end
        modeCode <= 2'b01;
        divSel <= 1;
        sel <= 3'h4;
        oscEn <= 1;
        repeat (20) @(posedge sys_clk);
        chk("pin enable", divOe, 1'b1);
        c0 = clkRises - oscRises;
        repeat (400) @(posedge sys_clk);
        a = clkRises - oscRises - c0;
        chk("clock out", a >= -1 && a <= 1, 1'b1);
        @(posedge divOut);
        t0 = $realtime;
        @(posedge divOut);
        chk("divider period", ($realtime - t0) > 44040 && ($realtime - t0) < 44075, 1'b1);
        // realign makes an edge only from the low half
        @(negedge divOut);
        fork
            genlock_far_side_inst.send_line(0, 200);
            begin
                @(negedge syncLine);
                t0 = $realtime;
                @(posedge divOut);
                chk("realign delay", ($realtime - t0) >= 208 && ($realtime - t0) <= 336, 1'b1);
            end
        join
        rd(`REG_INT_STATUS, d, r);
        chk("realign event", d[2], 1'b1);
        modeCode <= 2'b00;
        rd(`REG_STATUS, d, r);
        chk("div in use", d[5], 1'b1);
        give_verdict();
    end
endmodule
`default_nettype wire
